// File: hdl/fps_pkg.sv
// Shared types and constants for the bistable primitive set.
// How it works
// (RULE_01) Set when set-side output true, else clear.
// (RULE_02) Each primitive holds state until switched.
// (RULE_03) Unclocked set/reset: two set, two clear, ORed.
// (RULE_04) Any input may be inverted: false acts.
// (RULE_05) State stays after the set/clear pulse ends.
// (RULE_06) Stimulus matching current state changes nothing.
// (RULE_07) Set and clear together: both outputs true.
// (RULE_08) Driver avoids set and clear together.
// (RULE_09) Clock edge: set input sets, clear clears.
// (RULE_10) Both inputs false at edge: state kept.
// (RULE_11) Driver never gives both at the edge.
// (RULE_12) Inverted clock: falling edge is active.
// (RULE_13) Direct set/clear are levels, clock independent.
// (RULE_14) Toggle inverts on each input rise.
// (RULE_15) Inverted toggle input: acts on falling edge.
// (RULE_16) Unclocked J-K: first arrival wins, later ignored.
// (RULE_17) Clocked J-K, both true: toggles each edge.
// (RULE_18) Clocked J-K, one true: acts as set/reset.
// (RULE_19) Two-stage J-K output stage updates on edge.
// (RULE_20) Latch: data drives set, inverse drives clear.
// (RULE_21) Latch follows data while clock true, freezes.
// (RULE_22) Inverted latch clock: transparent while false.
// (RULE_23) Delay primitive samples data only at edge.
// (RULE_24) Complement output is inverse of true output.
package fps_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_POLARITY = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LEVELS   = 8'h08;

  // One bit per primitive input; the same layout serves as the polarity mask.
  typedef struct packed {
    logic rs_set_a;
    logic rs_set_c;
    logic rs_clr_b;
    logic rs_clr_d;
    logic crs_set;
    logic crs_clr;
    logic crs_clk;
    logic dir_set;
    logic dir_clr;
    logic tog_in;
    logic jk_set;
    logic jk_clr;
    logic cjk_set;
    logic cjk_clr;
    logic cjk_clk;
    logic lat_data;
    logic lat_clk;
    logic dly_data;
    logic dly_clk;
  } fps_stim_t;

  localparam int STIM_W = $bits(fps_stim_t);
  localparam fps_stim_t POLARITY_RESET = fps_stim_t'(19'h0_0000);

  typedef struct packed {
    logic set_side;
    logic clr_side;
  } fps_pair_t;

  typedef struct packed {
    fps_pair_t rs;
    fps_pair_t crs;
    fps_pair_t tog;
    fps_pair_t jk;
    fps_pair_t cjk;
    fps_pair_t lat;
    fps_pair_t dly;
  } fps_out_t;

  localparam int OUT_W = $bits(fps_out_t);
  localparam fps_out_t OUT_RESET = fps_out_t'(14'h1555);

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fps_bus_req_t;

  // Builds a complementary output pair from a stored state.
  function automatic fps_pair_t fps_pair(input logic q);
    fps_pair_t p;
    p.set_side = q;
    p.clr_side = ~q;
    return p;
  endfunction

endpackage

// File: hdl/fps_norm.sv
// Input polarity handling and active-edge detection for all primitive inputs.
`timescale 1ns/1ps
`default_nettype none
module fps_norm (
  // Clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_reset,
  // Raw inputs and polarity mask
  input  wire fps_pkg::fps_stim_t i_stim,
  input  wire fps_pkg::fps_stim_t i_polarity,
  // Normalised levels and active-edge pulses
  output var  fps_pkg::fps_stim_t o_level,
  output var  fps_pkg::fps_stim_t o_rise
);

  typedef struct packed {
    fps_pkg::fps_stim_t prev;
  } fps_norm_state_t;

  fps_norm_state_t st;
  fps_norm_state_t next_st;

  // Changing a polarity bit can fake one active edge; software should
  // reconfigure only while the primitives are idle.
  always_comb begin
    o_level      = i_stim ^ i_polarity; // RULE_04
    o_rise       = o_level & ~st.prev; // RULE_12
    next_st.prev = o_level;
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule // fps_norm
`default_nettype wire

// File: hdl/fps_regs.sv
// Register port: polarity configuration, output status and input levels.
`timescale 1ns/1ps
`default_nettype none
module fps_regs (
  // Clock and reset
  input  wire logic                        i_core_clk,
  input  wire logic                        i_reset,
  // Register port
  input  wire fps_pkg::fps_bus_req_t       i_bus,
  output logic      [fps_pkg::DATA_W-1:0]  o_rd_data,
  // Block side
  input  wire fps_pkg::fps_out_t           i_status,
  input  wire fps_pkg::fps_stim_t          i_level,
  output var  fps_pkg::fps_stim_t          o_polarity
);

  typedef struct packed {
    fps_pkg::fps_stim_t          polarity;
    logic [fps_pkg::DATA_W-1:0]  rd_data;
  } fps_regs_state_t;

  fps_regs_state_t st;
  fps_regs_state_t next_st;

  always_comb begin
    next_st         = st;
    next_st.rd_data = '0;
    if (i_bus.wr && i_bus.addr == fps_pkg::OFS_POLARITY) begin
      next_st.polarity = i_bus.wdata[fps_pkg::STIM_W-1:0];
    end
    if (i_bus.rd) begin
      case (i_bus.addr)
        fps_pkg::OFS_POLARITY: next_st.rd_data = fps_pkg::DATA_W'(st.polarity);
        fps_pkg::OFS_STATUS:   next_st.rd_data = fps_pkg::DATA_W'(i_status);
        fps_pkg::OFS_LEVELS:   next_st.rd_data = fps_pkg::DATA_W'(i_level);
        default:               next_st.rd_data = '0;
      endcase
    end
    o_rd_data  = st.rd_data;
    o_polarity = st.polarity;
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      st.polarity <= fps_pkg::POLARITY_RESET;
      st.rd_data  <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule // fps_regs
`default_nettype wire

// File: hdl/fps_top.sv
// Seven bistable primitives modelled on the core clock, with a register port.
`timescale 1ns/1ps
`default_nettype none
module fps_top (
  // Clock and reset
  input  wire logic                        i_core_clk,
  input  wire logic                        i_reset,
  // Register port
  input  wire fps_pkg::fps_bus_req_t       i_bus,
  output logic      [fps_pkg::DATA_W-1:0]  o_rd_data,
  // Primitive inputs
  input  wire fps_pkg::fps_stim_t          i_stim,
  // Primitive outputs
  output var  fps_pkg::fps_out_t           o_bistable_marker
);

  typedef struct packed {
    fps_pkg::fps_out_t out;
    logic              cjk_master;
  } fps_top_state_t;

  fps_top_state_t     st;
  fps_top_state_t     next_st;
  fps_pkg::fps_stim_t polarity;
  fps_pkg::fps_stim_t lvl;
  fps_pkg::fps_stim_t rise;

  fps_norm u_norm (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_stim     (i_stim),
    .i_polarity (polarity),
    .o_level    (lvl),
    .o_rise     (rise)
  );

  fps_regs u_regs (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_bus      (i_bus),
    .o_rd_data  (o_rd_data),
    .i_status   (st.out),
    .i_level    (lvl),
    .o_polarity (polarity)
  );

  always_comb begin
    logic rs_s;
    logic rs_c;
    logic q_rs;
    logic q_crs;
    logic q_tog;
    logic q_jk;
    logic q_cjk;
    logic q_lat;
    logic q_dly;
    logic direct;
    rs_s    = lvl.rs_set_a | lvl.rs_set_c; // RULE_03
    rs_c    = lvl.rs_clr_b | lvl.rs_clr_d; // RULE_03
    next_st = st;
    q_rs    = st.out.rs.set_side; // RULE_01
    q_crs   = st.out.crs.set_side;
    q_tog   = st.out.tog.set_side;
    q_jk    = st.out.jk.set_side;
    q_cjk   = st.out.cjk.set_side;
    q_lat   = st.out.lat.set_side;
    q_dly   = st.out.dly.set_side;
    direct  = lvl.dir_set | lvl.dir_clr;

    // Unclocked set/reset. During overlap both outputs are true and the state reads as set, so the input
    // still active after the other drops decides the outcome.
    if (rs_s && !rs_c) begin
      q_rs = 1'b1; // RULE_05
    end else if (rs_c && !rs_s) begin
      q_rs = 1'b0; // RULE_06
    end

    // Unclocked J-K reacts to arrivals only; a request arriving while the
    // other is already held is ignored, and a tie leaves the state alone.
    if (rise.jk_set && !lvl.jk_clr && !rise.jk_clr) begin
      q_jk = 1'b1; // RULE_16
    end else if (rise.jk_clr && !lvl.jk_set && !rise.jk_set) begin
      q_jk = 1'b0; // RULE_16
    end

    // Direct inputs are level driven and override the clock; set wins a tie.
    if (direct) begin
      q_crs          = lvl.dir_set; // RULE_13
      q_tog          = lvl.dir_set;
      q_cjk          = lvl.dir_set;
      q_dly          = lvl.dir_set;
      next_st.cjk_master = lvl.dir_set;
    end else begin
      if (rise.crs_clk) begin // RULE_09
        if (lvl.crs_set && !lvl.crs_clr) begin
          q_crs = 1'b1; // RULE_09
        end else if (lvl.crs_clr && !lvl.crs_set) begin
          q_crs = 1'b0; // RULE_09
        end
        // Neither or both (the latter forbidden to the driver) hold state.
      end // RULE_10 RULE_11
      if (rise.tog_in) begin
        q_tog = ~q_tog; // RULE_14 RULE_15
      end
      // First stage tracks J-K inputs while the clock is inactive; the output
      // stage takes it over at the active edge.
      if (!lvl.cjk_clk) begin
        case ({lvl.cjk_set, lvl.cjk_clr})
          2'h3:    next_st.cjk_master = ~q_cjk; // RULE_17
          2'h2:    next_st.cjk_master = 1'b1; // RULE_18
          2'h1:    next_st.cjk_master = 1'b0; // RULE_18
          default: next_st.cjk_master = q_cjk;
        endcase
      end
      if (rise.cjk_clk) begin
        q_cjk = st.cjk_master; // RULE_19
      end
      if (rise.dly_clk) begin
        q_dly = lvl.dly_data; // RULE_23
      end
    end

    // Latch: transparent while its normalised clock is active.
    if (lvl.lat_clk) begin
      q_lat = lvl.lat_data; // RULE_20 RULE_21 RULE_22
    end

    // Outputs stay complementary except for the unclocked overlap case.
    next_st.out.rs  = (rs_s && rs_c) ? fps_pkg::fps_pair_t'(2'h3) : fps_pkg::fps_pair(q_rs); // RULE_07
    next_st.out.crs = fps_pkg::fps_pair(q_crs); // RULE_24
    next_st.out.tog = fps_pkg::fps_pair(q_tog);
    next_st.out.jk  = fps_pkg::fps_pair(q_jk);
    next_st.out.cjk = fps_pkg::fps_pair(q_cjk);
    next_st.out.lat = fps_pkg::fps_pair(q_lat);
    next_st.out.dly = fps_pkg::fps_pair(q_dly);
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      st.out        <= fps_pkg::OUT_RESET;
      st.cjk_master <= 1'b0;
    end else begin
      st <= next_st; // RULE_02
    end
  end

  assign o_bistable_marker = st.out;

endmodule // fps_top
`default_nettype wire

// File: sim/fps_properties.sv
// Port checker for the bistable primitive set.
`timescale 1ns/1ps
`default_nettype none
module fps_properties (
  // Clock and reset
  input wire logic                  i_core_clk,
  input wire logic                  i_reset,
  // Register port
  input wire fps_pkg::fps_bus_req_t i_bus,
  input wire logic [31:0]           o_rd_data,
  // Primitives
  input wire fps_pkg::fps_stim_t    i_stim,
  input wire fps_pkg::fps_out_t     o_bistable_marker
);
  fps_pkg::fps_stim_t pol;
  fps_pkg::fps_stim_t n;
  fps_pkg::fps_out_t  q;
  logic               d, s, c;
  // Mirror of the polarity mask, so inputs are judged as the primitives see them.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) pol <= '0;
    else if (i_bus.wr && i_bus.addr == 8'h00) pol <= i_bus.wdata[18:0];
  end
  assign n = i_stim ^ pol;
  assign q = o_bistable_marker;
  assign d = n.dir_set | n.dir_clr;
  assign s = n.rs_set_a | n.rs_set_c;
  assign c = n.rs_clr_b | n.rs_clr_d;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  rs_set_a: assert property (s && !c |=> q.rs == 2'h2) else $error("rs not set");
  rs_both_a: assert property (s && c |=> q.rs == 2'h3) else $error("rs overlap");
  crs_edge_a: assert property (
    n.crs_clk && !$past(n.crs_clk) && n.crs_set != n.crs_clr && !d
    |=> q.crs == {$past(n.crs_set), $past(n.crs_clr)}) else $error("crs edge");
  dir_set_a: assert property (
    n.dir_set |=> q.crs == 2'h2 && q.tog == 2'h2 && q.dly == 2'h2) else $error("direct set");
  tog_flip_a: assert property (
    n.tog_in && !$past(n.tog_in) && !d |=> q.tog == ~$past(q.tog)) else $error("toggle");
  lat_follow_a: assert property (
    n.lat_clk |=> q.lat == {$past(n.lat_data), !$past(n.lat_data)}) else $error("latch");
  dly_edge_a: assert property (
    n.dly_clk && !$past(n.dly_clk) && !d |=> q.dly.set_side == $past(n.dly_data)) else $error("delay");
  pair_inv_a: assert property (&{^q.crs, ^q.tog, ^q.jk, ^q.cjk, ^q.lat, ^q.dly}) else $error("pair");
endmodule // fps_properties
bind fps_top fps_properties i_fps_properties (.i_core_clk, .i_reset, .i_bus, .o_rd_data, .i_stim,
  .o_bistable_marker);
`default_nettype wire

// File: sim/fps_partner.sv
// Surrounding logic: one clock pulse for the clocked set/reset primitive.
`timescale 1ns/1ps
`default_nettype none
module fps_partner (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_reset,
  // Request, prompt or slow
  input  wire logic i_go,
  input  wire logic i_slow,
  // Primitive clock, low outside the pulse
  output logic      o_pulse
);
  logic [1:0] cnt;
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt     <= 2'h0;
      o_pulse <= 1'b0;
    end else begin
      cnt     <= i_go ? (i_slow ? 2'h3 : 2'h1) : (cnt == 2'h0 ? 2'h0 : cnt - 2'h1);
      o_pulse <= cnt == 2'h1;
    end
  end
endmodule // fps_partner
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the bistable primitive set.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench;
  logic                  clk, pulse;
  logic                  rst = 1'b1, go = 1'b0, slow = 1'b0;
  fps_pkg::fps_bus_req_t bus = '0;
  fps_pkg::fps_stim_t    st = '0;
  fps_pkg::fps_out_t     o;
  logic [31:0]           rdd;
  int                    miscompares = 0;
  int                    total_checks = 0;
  fps_top i_fps_top (.i_core_clk(clk), .i_reset(rst), .i_bus(bus), .o_rd_data(rdd),
    .i_stim({st[18:13], pulse, st[11:0]}), .o_bistable_marker(o));
  fps_partner i_fps_partner (.i_core_clk(clk), .i_reset(rst), .i_go(go), .i_slow(slow), .o_pulse(pulse));
  task automatic final_report;
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Outputs land at the edge that samples the stimulus, so pair k is checked just past that edge.
  task automatic t(input logic [18:0] v, input int k, input logic [1:0] e);
    @(posedge clk);
    st <= v;
    @(posedge clk);
    #1;
    `CHK("output pair", e, o[2*k +: 2])
  endtask
  task automatic bx(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{w, !w, a, w ? v : 32'h0};
    @(posedge clk);
    bus <= '0;
    #1;
    if (!w) `CHK("read data", v, rdd)
  endtask
  task automatic pz(input logic sl, input logic [1:0] e);
    @(posedge clk);
    go <= 1'b1;
    slow <= sl;
    @(posedge clk);
    go <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    `CHK("clocked pair", e, o.crs)
  endtask
  task automatic s_rs;
    t(19'h4_0000, 6, 2'h2);
    t(19'h4_0000, 6, 2'h2);
    t(19'h0_0000, 6, 2'h2);
    t(19'h0_8000, 6, 2'h1);
    t(19'h2_8000, 6, 2'h3);
    t(19'h0_8000, 6, 2'h1);
  endtask
  task automatic s_jk;
    t(19'h0_0100, 3, 2'h2);
    t(19'h0_0180, 3, 2'h2);
    t(19'h0_0080, 3, 2'h2);
    t(19'h0_0000, 3, 2'h2);
    t(19'h0_0080, 3, 2'h1);
    t(19'h0_0060, 2, 2'h1);
    t(19'h0_0070, 2, 2'h2);
    t(19'h0_0060, 2, 2'h2);
    t(19'h0_0070, 2, 2'h1);
    t(19'h0_0040, 2, 2'h1);
    t(19'h0_0050, 2, 2'h2);
    t(19'h0_0020, 2, 2'h2);
    t(19'h0_0030, 2, 2'h1);
    t(19'h0_0000, 2, 2'h1);
    bx(1'b1, 8'h00, 32'h0000_0010);
    t(19'h0_0070, 2, 2'h1);
    t(19'h0_0060, 2, 2'h2);
    bx(1'b1, 8'h00, 32'h0000_0000);
  endtask
  task automatic s_tog;
    t(19'h0_0200, 4, 2'h2);
    t(19'h0_0000, 4, 2'h2);
    t(19'h0_0200, 4, 2'h1);
    bx(1'b1, 8'h00, 32'h0000_0200);
    t(19'h0_0000, 4, 2'h2);
    bx(1'b0, 8'h00, 32'h0000_0200);
    bx(1'b1, 8'h00, 32'h0000_0000);
  endtask
  task automatic s_hold;
    t(19'h0_000C, 1, 2'h2);
    t(19'h0_0004, 1, 2'h1);
    t(19'h0_0008, 1, 2'h1);
    bx(1'b1, 8'h00, 32'h0000_0004);
    t(19'h0_0000, 1, 2'h1);
    bx(1'b1, 8'h00, 32'h0000_0000);
    t(19'h0_0003, 0, 2'h2);
    t(19'h0_0001, 0, 2'h2);
  endtask
  task automatic s_crs;
    t(19'h0_4000, 5, 2'h1);
    pz(1'b1, 2'h2);
    t(19'h0_2000, 5, 2'h2);
    pz(1'b0, 2'h1);
    t(19'h0_0C00, 5, 2'h2);
    t(19'h0_0400, 0, 2'h1);
    bx(1'b0, 8'h04, 32'h0000_1555);
    bx(1'b0, 8'h0C, 32'h0000_0000);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK("outputs", fps_pkg::OUT_RESET, o)
    s_rs();
    s_tog();
    s_hold();
    s_jk();
    s_crs();
    final_report();
  end
  initial begin
    #20000;
    miscompares++;
    final_report();
  end
endmodule // testbench
`default_nettype wire
